// file: bench/conv_dev_model.sv
module conv_dev_model #(
    parameter int BUSY_DLY = 2,
    parameter int CONV_CYC = 40
)
(
    // Clock
    input  wire logic core_clk_in,
    // Host pins
    input  wire logic start_a_in,
    input  wire logic start_b_in,
    input  wire logic reset_in,
    input  wire logic power_down_n_in,
    // Bench control: a muted device never answers a start
    input  wire logic mute_in,
    // Status
    output logic      busy_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic     st_q = 1'b0;
    int       cnt = 0;
    wire logic st = start_a_in | start_b_in;
    // Powered down or in reset: no conversion runs
    always_ff @(posedge core_clk_in)
    begin
        st_q <= st;
        if (reset_in || !power_down_n_in)
            cnt <= 0;
        else if (st && !st_q && cnt == 0 && !mute_in)
            cnt <= BUSY_DLY + CONV_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign busy_out = (cnt != 0) && (cnt <= CONV_CYC);
endmodule : conv_dev_model

// file: bench/conv_seq_host_bench.sv
module conv_seq_host_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import conv_seq_pkg::*;
    logic core_clk_in = 1'b0, rst_n_in = 1'b0, rreq = 1'b0, pup = 1'b0, shut = 1'b0;
    logic ext = 1'b0, slow = 1'b0, sreq = 1'b0, dur = 1'b0, rdone = 1'b0, mute = 1'b0;
    logic ready, rok, cdone, tmo, busy, sa, sb, drst, pdn, sa_q, pdn_q;
    int   n_fail = 0, n_checks = 0, cyc = 0, t_sa = 0, t_pdn = 0;
    always #4 core_clk_in = ~core_clk_in;
    conv_seq_host #(.STANDBY_WAKE_CYCLES(20), .SHUTDOWN_INT_CYCLES(40),
        .SHUTDOWN_EXT_CYCLES(30), .START_SKEW_CYCLES(20)) i_dut (.core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in), .reset_req_in(rreq), .power_up_in(pup), .from_shutdown_in(shut),
        .external_ref_in(ext), .slow_serial_in(slow), .start_req_in(sreq),
        .read_during_in(dur), .read_done_in(rdone), .ready_out(ready), .read_ok_out(rok),
        .conv_done_out(cdone), .timeout_out(tmo), .busy_in(busy), .start_group_a_out(sa),
        .start_group_b_out(sb), .device_reset_out(drst), .power_down_n_out(pdn));
    conv_dev_model i_dev (.core_clk_in(core_clk_in), .start_a_in(sa), .start_b_in(sb),
        .reset_in(drst), .power_down_n_in(pdn), .mute_in(mute), .busy_out(busy));
    // Edge times kept by the bench, never read back from the design
    always @(posedge core_clk_in)
    begin
        cyc++;
        if (sa === 1'b1 && sa_q !== 1'b1) t_sa = cyc;
        if (pdn === 1'b1 && pdn_q !== 1'b1) t_pdn = cyc;
        sa_q = sa;
        pdn_q = pdn;
        if (cyc == 20000) begin n_fail++; wrap_up(); end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp) begin n_fail++; $display("ERROR %0t %s", $time, m); end
    endtask : check
    task automatic wait_for(ref logic s);
        for (int i = 0; i < 3000 && s !== 1'b1; i++) @(negedge core_clk_in);
    endtask : wait_for
    task automatic t_dev_reset();
        int n;
        n = 0;
        @(negedge core_clk_in) rreq = 1'b1;
        @(negedge core_clk_in) rreq = 1'b0;
        wait_for(drst);
        while (drst === 1'b1 && n < 20) begin n++; @(negedge core_clk_in); end
        check(n, 7, "reset width");
        check(sa, 1'b0, "start in reset gap");
    endtask : t_dev_reset
    task automatic t_wake(input logic s, input logic e, input int exp);
        @(negedge core_clk_in) pup = 1'b0;
        repeat (5) @(negedge core_clk_in);
        {shut, ext, pup, sreq} = {s, e, 2'b11};
        wait_for(sa);
        // Let the edge monitor log the start before it is read
        @(negedge core_clk_in) sreq = 1'b0;
        check(pdn, 1'b1, "not powered");
        check(t_sa - t_pdn >= exp, 1'b1, "wake wait short");
        wait_for(cdone);
    endtask : t_wake
    task automatic t_conv(input logic s, input logic d);
        int t0;
        {slow, dur} = {s, d};
        wait_for(ready);
        sreq = 1'b1;
        @(negedge core_clk_in) sreq = 1'b0;
        wait_for(busy);
        // Busy is seen one cycle after it rises, then the sequencer enters conversion
        repeat (2) @(negedge core_clk_in);
        check(rok, d, "read grant in conversion");
        {rdone} = d;
        @(negedge core_clk_in) rdone = 1'b0;
        check(rok, 1'b0, "grant kept after read done");
        wait_for(cdone);
        @(negedge core_clk_in) check(rok, 1'b1, "no read after busy fell");
        check(cdone, 1'b0, "done pulse too long");
        check(ready, 1'b0, "ready before spacing elapsed");
        t0 = t_sa;
        sreq = 1'b1;
        wait_for(sa);
        @(negedge core_clk_in) sreq = 1'b0;
        check(t_sa - t0 >= (s ? CYCLE_SLOW_CYC : CYCLE_FAST_CYC), 1'b1, "gap");
        wait_for(cdone);
    endtask : t_conv
    task automatic t_busy_lost();
        mute = 1'b1;
        wait_for(ready);
        sreq = 1'b1;
        @(negedge core_clk_in) sreq = 1'b0;
        wait_for(tmo);
        check(tmo, 1'b1, "no timeout without busy");
        check(cdone, 1'b0, "done without busy");
        @(negedge core_clk_in) mute = 1'b0;
        check(tmo, 1'b0, "timeout pulse too long");
    endtask : t_busy_lost
    task automatic wrap_up();
        $display("checks %0d fails %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : wrap_up
    initial
    begin
        repeat (10) @(negedge core_clk_in);
        rst_n_in = 1'b1;
        t_wake(1'b0, 1'b0, 20);
        t_dev_reset();
        t_conv(1'b0, 1'b1);
        t_conv(1'b1, 1'b0);
        t_busy_lost();
        t_wake(1'b1, 1'b1, 30);
        t_wake(1'b1, 1'b0, 40);
        wrap_up();
    end
endmodule : conv_seq_host_bench

// file: bench/conv_seq_props.sv
module conv_seq_props
    import conv_seq_pkg::*;
#(
    parameter int STANDBY_WAKE_CYCLES = 20,
    parameter int SHUTDOWN_INT_CYCLES = 40,
    parameter int SHUTDOWN_EXT_CYCLES = 30
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic read_during_in,
    input wire logic from_shutdown_in,
    input wire logic external_ref_in,
    input wire logic slow_serial_in,
    input wire logic busy_in,
    input wire logic read_ok_out,
    input wire logic conv_done_out,
    input wire logic start_group_a_out,
    input wire logic start_group_b_out,
    input wire logic device_reset_out,
    input wire logic power_down_n_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [15:0] gap, wake, need;
    logic        a_q, p_q, seen, dur_l, slow_l;
    wire logic   rise  = start_group_a_out & ~a_q;
    wire logic   prise = power_down_n_out & ~p_q;
    // Saturating counters so long idle stretches never wrap
    always_ff @(posedge core_clk_in)
    begin
        a_q  <= rst_n_in & start_group_a_out;
        p_q  <= rst_n_in & power_down_n_out;
        seen <= rst_n_in & (seen | rise);
        gap  <= rise ? 16'h0000 : gap + {15'h0000, gap != 16'hFFFF};
        wake <= prise ? 16'h0000 : wake + {15'h0000, wake != 16'hFFFF};
        if (rise)
            dur_l <= read_during_in;
        // Mode of the start that opens a cycle governs its length
        if (rise)
            slow_l <= slow_serial_in;
        if (prise)
            need <= 16'(!from_shutdown_in ? STANDBY_WAKE_CYCLES :
                        external_ref_in ? SHUTDOWN_EXT_CYCLES : SHUTDOWN_INT_CYCLES);
    end
    property p_pair; start_group_a_out == start_group_b_out; endproperty
    a_pair: assert property (p_pair) else $error("start lines differ");
    property p_rst_w; $rose(device_reset_out) |-> device_reset_out [*7]; endproperty
    a_rst_w: assert property (p_rst_w) else $error("reset pulse short");
    property p_rst_gap; $fell(device_reset_out) |-> !start_group_a_out [*4]; endproperty
    a_rst_gap: assert property (p_rst_gap) else $error("start too soon after reset");
    property p_fast; rise && seen |-> gap >= CYCLE_FAST_CYC - 1; endproperty
    a_fast: assert property (p_fast) else $error("starts too close");
    property p_slow; rise && seen && slow_l |-> gap >= CYCLE_SLOW_CYC - 1; endproperty
    a_slow: assert property (p_slow) else $error("slow cycle too short");
    property p_wake; rise |-> wake >= need - 16'h0001; endproperty
    a_wake: assert property (p_wake) else $error("start before wake time");
    property p_rok; busy_in && read_ok_out |-> dur_l; endproperty
    a_rok: assert property (p_rok) else $error("read granted while busy");
    property p_done; $fell(busy_in) |=> conv_done_out; endproperty
    a_done: assert property (p_done) else $error("no done after busy fell");
    property p_rd_end; $fell(busy_in) |=> !read_ok_out; endproperty
    a_rd_end: assert property (p_rd_end) else $error("read grant outlives busy");
endmodule : conv_seq_props

bind conv_seq_host conv_seq_props #(
    .STANDBY_WAKE_CYCLES(STANDBY_WAKE_CYCLES), .SHUTDOWN_INT_CYCLES(SHUTDOWN_INT_CYCLES),
    .SHUTDOWN_EXT_CYCLES(SHUTDOWN_EXT_CYCLES)) i_props (.core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in), .read_during_in(read_during_in), .from_shutdown_in(from_shutdown_in),
    .external_ref_in(external_ref_in), .slow_serial_in(slow_serial_in), .busy_in(busy_in),
    .read_ok_out(read_ok_out),
    .conv_done_out(conv_done_out), .start_group_a_out(start_group_a_out),
    .start_group_b_out(start_group_b_out), .device_reset_out(device_reset_out),
    .power_down_n_out(power_down_n_out));

// file: logic/conv_cycle_timer.sv
module conv_cycle_timer
    import conv_seq_pkg::*;
(
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             load_in,
    input  wire logic [CNT_W-1:0] count_in,
    // Status
    output logic                  done_out
);
    logic [CNT_W-1:0] remaining;
    logic [CNT_W-1:0] next_remaining;

    always_comb
    begin
        next_remaining = remaining;
        if (load_in)
        begin
            next_remaining = count_in;
        end
        else if (remaining != {CNT_W{1'b0}})
        begin
            next_remaining = remaining - {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            remaining <= {CNT_W{1'b0}};
        end
        else
        begin
            remaining <= next_remaining;
        end
    end

    assign done_out = (remaining == {CNT_W{1'b0}}) && !load_in;
endmodule : conv_cycle_timer

// file: logic/conv_seq_host.sv
module conv_seq_host
    import conv_seq_pkg::*;
#(
    parameter int STANDBY_WAKE_CYCLES = STANDBY_WAKE_CYC,
    parameter int SHUTDOWN_INT_CYCLES = SHUTDOWN_INT_CYC,
    parameter int SHUTDOWN_EXT_CYCLES = SHUTDOWN_EXT_CYC,
    parameter int START_SKEW_CYCLES   = START_SKEW_CYC
)
(
    // Clock and reset
    input  wire logic core_clk_in,
    input  wire logic rst_n_in,
    // User requests
    input  wire logic reset_req_in,
    input  wire logic power_up_in,
    input  wire logic from_shutdown_in,
    input  wire logic external_ref_in,
    input  wire logic slow_serial_in,
    input  wire logic start_req_in,
    input  wire logic read_during_in,
    input  wire logic read_done_in,
    // User status
    output logic      ready_out,
    output logic      read_ok_out,
    output logic      conv_done_out,
    output logic      timeout_out,
    // Device pins
    input  wire logic busy_in,
    output logic      start_group_a_out,
    output logic      start_group_b_out,
    output logic      device_reset_out,
    output logic      power_down_n_out
);
    seq_state_e       state;
    seq_state_e       next_state;
    logic             pwr;
    logic             next_pwr;
    logic             reading;
    logic             next_reading;
    logic             done_flag;
    logic             next_done_flag;
    logic             tmo;
    logic             next_tmo;
    logic             spacing_done;
    logic             spacing_load;
    logic [CNT_W-1:0] spacing_count;
    logic [CNT_W-1:0] phase_cnt;
    logic [CNT_W-1:0] next_phase_cnt;

    // Cast keeps every loaded count at the counter width
    function automatic logic [CNT_W-1:0] cyc(input int n);
        cyc = CNT_W'(n);
    endfunction : cyc

    //////////////////////////////////////////////////////////////////////////
    // Sample cycle spacing, loaded in the first ST_START cycle, one cycle before each start edge
    assign spacing_load  = (state == ST_START) && (phase_cnt == {CNT_W{1'b0}});
    assign spacing_count = slow_serial_in ? cyc(CYCLE_SLOW_CYC - 1)
                                          : cyc(CYCLE_FAST_CYC - 1);

    conv_cycle_timer u_spacing
    (
        .core_clk_in (core_clk_in),
        .rst_n_in    (rst_n_in),
        .load_in     (spacing_load),
        .count_in    (spacing_count),
        .done_out    (spacing_done)
    );

    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        next_state     = state;
        next_pwr       = pwr;
        next_reading   = reading;
        next_done_flag = 1'b0;
        next_tmo       = 1'b0;
        next_phase_cnt = (phase_cnt == {CNT_W{1'b0}}) ? phase_cnt
                         : phase_cnt - {{(CNT_W-1){1'b0}}, 1'b1};
        unique case (state)
            ST_IDLE:
            begin
                if (reset_req_in)
                begin
                    next_state     = ST_RESET;
                    next_phase_cnt = cyc(RESET_HIGH_CYC - 1);
                end
                else if (power_up_in && !pwr)
                begin
                    next_pwr       = 1'b1;
                    next_state     = ST_WAKE;
                    // Standby wake is far shorter than shutdown wake
                    if (!from_shutdown_in)
                    begin
                        next_phase_cnt = cyc(STANDBY_WAKE_CYCLES - 1);
                    end
                    else if (external_ref_in)
                    begin
                        next_phase_cnt = cyc(SHUTDOWN_EXT_CYCLES - 1);
                    end
                    else
                    begin
                        next_phase_cnt = cyc(SHUTDOWN_INT_CYCLES - 1);
                    end
                end
                else if (!power_up_in && pwr)
                begin
                    next_pwr = 1'b0;
                end
                // Start only once the previous sample cycle has run out
                else if (start_req_in && pwr && spacing_done)
                begin
                    next_state     = ST_START;
                    next_phase_cnt = {CNT_W{1'b0}};
                    next_reading   = read_during_in;
                end
            end
            ST_RESET:
            begin
                // Reset held high, then a gap before any start edge
                if (phase_cnt == {CNT_W{1'b0}})
                begin
                    next_state     = ST_WAKE;
                    next_phase_cnt = cyc(RESET_TO_START_CYC - 1);
                end
            end
            ST_WAKE:
            begin
                if (phase_cnt == {CNT_W{1'b0}})
                begin
                    next_state = ST_IDLE;
                end
            end
            ST_START:
            begin
                // Both start lines rise on one edge, so skew is zero
                if (phase_cnt == {CNT_W{1'b0}})
                begin
                    next_phase_cnt = cyc(START_PULSE_CYC);
                end
                else if (phase_cnt == {{(CNT_W-1){1'b0}}, 1'b1})
                begin
                    next_state     = ST_WAIT_BUSY;
                    next_phase_cnt = cyc(START_SKEW_CYCLES);
                end
            end
            ST_WAIT_BUSY:
            begin
                // A device that never answers must not hang the sequencer
                if (busy_in)
                begin
                    next_state = ST_CONVERT;
                end
                else if (phase_cnt == {CNT_W{1'b0}})
                begin
                    next_tmo   = 1'b1;
                    next_state = ST_IDLE;
                end
            end
            ST_CONVERT:
            begin
                // Grant for a read during conversion ends one cycle after busy falls at the latest
                if (read_done_in)
                begin
                    next_reading = 1'b0;
                end
                if (!busy_in)
                begin
                    next_done_flag = 1'b1;
                    next_reading   = 1'b0;
                    next_state     = ST_SPACING;
                end
            end
            ST_SPACING:
            begin
                next_state = ST_IDLE;
            end
            default:
            begin
                next_state = ST_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Sequencer state and counters
    always_ff @(posedge core_clk_in)
    begin
        if (!rst_n_in)
        begin
            state     <= ST_IDLE;
            pwr       <= 1'b0;
            reading   <= 1'b0;
            done_flag <= 1'b0;
            tmo       <= 1'b0;
            phase_cnt <= {CNT_W{1'b0}};
        end
        else
        begin
            state     <= next_state;
            pwr       <= next_pwr;
            reading   <= next_reading;
            done_flag <= next_done_flag;
            tmo       <= next_tmo;
            phase_cnt <= next_phase_cnt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Readout permission: after busy falls, or during conversion
    assign read_ok_out = ((state == ST_IDLE) && pwr && !busy_in)
                         || ((state == ST_CONVERT) && reading);

    assign ready_out         = (state == ST_IDLE) && pwr && spacing_done;
    assign conv_done_out     = done_flag;
    assign timeout_out       = tmo;
    // Device pins decode state and phase_cnt, power follows pwr, group B copies group A
    assign start_group_a_out = (state == ST_START) && (phase_cnt != {CNT_W{1'b0}});
    assign start_group_b_out = start_group_a_out;
    assign device_reset_out  = (state == ST_RESET);
    assign power_down_n_out  = pwr;
endmodule : conv_seq_host

// file: logic/conv_seq_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Contract
// - Wait at least 100 us after leaving standby before a start edge.
// - After shutdown wait 30 ms (internal ref) or 13 ms (external ref).
// - Separately driven start edges lie within 0.5 ms of each other.
// - Chip select is not asserted for readout before busy has fallen.
// - A read during conversion ends within 25 ns after busy falls.
// - Starts are spaced at least 5 us apart in fast modes.
// - Slow serial mode allows a sample cycle of 10.5 us.
// - Reset pulse is held high for at least 50 ns.
// - Wait at least 25 ns after reset low before a start edge.
//////////////////////////////////////////////////////////////////////////////
package conv_seq_pkg;
    localparam int CLK_PERIOD_PS       = 8000;
    localparam int STANDBY_WAKE_US     = 100;
    localparam int SHUTDOWN_INT_MS     = 30;
    localparam int SHUTDOWN_EXT_MS     = 13;
    localparam int START_SKEW_PS       = 500000000;
    localparam int BUSY_RISE_NS        = 40;
    localparam int CYCLE_FAST_NS       = 5000;
    localparam int CYCLE_SLOW_NS       = 10500;
    localparam int RESET_HIGH_NS       = 50;
    localparam int RESET_TO_START_NS   = 25;
    localparam int START_PULSE_NS      = 25;
    // Least times round up, longest times round down
    localparam int STANDBY_WAKE_CYC    = (STANDBY_WAKE_US * 1000000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int SHUTDOWN_INT_CYC    = (SHUTDOWN_INT_MS * 125000);
    localparam int SHUTDOWN_EXT_CYC    = (SHUTDOWN_EXT_MS * 125000);
    localparam int START_SKEW_CYC      = START_SKEW_PS / CLK_PERIOD_PS;
    localparam int BUSY_RISE_CYC       = (BUSY_RISE_NS * 1000) / CLK_PERIOD_PS;
    localparam int CYCLE_FAST_CYC      = (CYCLE_FAST_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int CYCLE_SLOW_CYC      = (CYCLE_SLOW_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int RESET_HIGH_CYC      = (RESET_HIGH_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int RESET_TO_START_CYC  = (RESET_TO_START_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int START_PULSE_CYC     = (START_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                         / CLK_PERIOD_PS;
    localparam int CNT_W               = 24;

    typedef enum logic [2:0]
    {
        ST_IDLE,
        ST_RESET,
        ST_WAKE,
        ST_START,
        ST_WAIT_BUSY,
        ST_CONVERT,
        ST_SPACING
    } seq_state_e;
endpackage : conv_seq_pkg
